// ---- fmac_chk.sv ----
`timescale 1ns/1ps
module fmac_chk #(
    parameter int NUM_CH = 4
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic GROUP_BUTTON,
    input wire logic TEST_BUTTON,
    input wire logic PSU_FAIL,
    input wire logic [NUM_CH-1:0] ZERO_BUTTON,
    input wire logic [NUM_CH-1:0] PROBE_PRESENT,
    input wire logic [NUM_CH-1:0] OK_RELAY,
    input wire logic [NUM_CH-1:0] WARN_RELAY,
    input wire logic [NUM_CH-1:0] ALARM_RELAY,
    input wire logic [NUM_CH-1:0] WARN_LED,
    input wire logic [NUM_CH-1:0] ALARM_LED,
    input wire logic SYS_RELAY,
    input wire logic LOCK_LED,
    input wire logic POWER_LED,
    input wire logic TEST_SHIFT,
    input wire logic [NUM_CH-1:0] ZERO_ACTIVE,
    input wire logic [NUM_CH*2-1:0] ZERO_RESULT
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    ////////////////////////////////////////
    AST_PWR_STEADY: assert property (!PSU_FAIL [*4] |-> POWER_LED)
        else $error("power LED not steady");
    AST_PSU_SYS: assert property (PSU_FAIL [*3] |-> !SYS_RELAY)
        else $error("system relay closed on supply failure");
    AST_ALM_SYS: assert property ((ALARM_RELAY != '1) [*2] |-> !SYS_RELAY)
        else $error("system relay closed with alarm relay open");
    AST_NOPROBE: assert property ($stable(PROBE_PRESENT) [*3] |-> (OK_RELAY & ~PROBE_PRESENT) == '0)
        else $error("OK relay closed without probe");
    AST_WARN_PAIR: assert property (!$past(RST) |-> (WARN_LED ^ WARN_RELAY) == '1)
        else $error("warning LED and relay disagree");
    AST_ALM_PAIR: assert property (!$past(RST) |-> (ALARM_LED ^ ALARM_RELAY) == '1)
        else $error("alarm LED and relay disagree");
    AST_GRP_DIS: assert property ($rose(GROUP_BUTTON) && !LOCK_LED |-> ##[1:4] OK_RELAY == '0)
        else $error("group press left a channel on");
    AST_LOCK_HOLD: assert property (LOCK_LED && $rose(GROUP_BUTTON) |-> (OK_RELAY == $past(OK_RELAY)) [*4])
        else $error("locked panel obeyed a button");
    AST_TEST_ON: assert property ((TEST_BUTTON && !LOCK_LED) [*3] |-> TEST_SHIFT)
        else $error("test shift missing");
    AST_TEST_OFF: assert property (!TEST_BUTTON [*3] |-> !TEST_SHIFT)
        else $error("test shift stuck");
    AST_ZERO_RES: assert property ((ZERO_RESULT & (ZERO_RESULT >> 1) & {NUM_CH{2'b01}}) == '0)
        else $error("zero done and fault together");
    AST_ZERO_START: assert property ($rose(ZERO_ACTIVE[1]) |-> !ZERO_BUTTON[1])
        else $error("auto-zero began while button held");
endmodule
bind fmac_top fmac_chk #(.NUM_CH(NUM_CH)) fmac_chk_inst (.*);

// ---- fmac_field.sv ----
`timescale 1ns/1ps
module fmac_field (
    input wire logic clk,
    input wire logic [63:0] level,
    input wire logic [3:0] attach,
    input wire logic pulse_req,
    output logic [63:0] reading,
    output logic [3:0] present,
    output logic contact
);
    logic [3:0] hold_cnt = 4'h0;
    logic [63:0] drift = 64'h0;
    ////////////////////////////////////////
    // Unplugged lanes float, so they toggle rather than hold a tidy value
    always_ff @(posedge clk) begin
        drift <= ~drift;
        if (pulse_req) begin
            hold_cnt <= 4'h8;
        end else if (hold_cnt != 4'h0) begin
            hold_cnt <= hold_cnt - 4'h1;
        end
    end
    assign contact = (hold_cnt != 4'h0);
    assign present = attach;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            reading[i*16 +: 16] = attach[i] ? level[i*16 +: 16] : drift[i*16 +: 16];
        end
    end
endmodule

// ---- fmac_pkg.sv ----
package fmac_pkg;

    // Channel count and reading width
    localparam int NUM_CH = 4;
    localparam int RD_W = 16;

    // Register indices on the plain register port
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_WARN_LVL = 4'h1;
    localparam logic [3:0] REG_ALARM_LVL = 4'h2;
    localparam logic [3:0] REG_DELAY = 4'h3;
    localparam logic [3:0] REG_AZ_TIME = 4'h4;
    localparam logic [3:0] REG_AZ_LVL = 4'h5;
    localparam logic [3:0] REG_CMD = 4'h6;
    localparam logic [3:0] REG_STATUS = 4'h7;
    localparam logic [3:0] REG_CHMODE = 4'h8;
    localparam logic [3:0] REG_ZOFS0 = 4'h9;

    // CTRL field positions
    localparam int CTRL_LATCH_BIT = 0;
    localparam int CTRL_MASTER_BIT = 1;
    localparam int CTRL_LOCK_BIT = 2;
    localparam int CTRL_FWRX_BIT = 3;
    localparam int CTRL_FWDONE_BIT = 4;

    // CMD field positions (write-one pulses)
    localparam int CMD_GRP_BIT = 0;
    localparam int CMD_RESET_BIT = 1;
    localparam int CMD_LOCK_SET_BIT = 2;
    localparam int CMD_LOCK_CLR_BIT = 3;

    // Reset values and the zero-offset step
    localparam logic [7:0] CTRL_RST = 8'h01;
    localparam logic [RD_W-1:0] WARN_RST = 16'h01f4;
    localparam logic [RD_W-1:0] ALARM_RST = 16'h2328;
    localparam logic [7:0] DELAY_RST_S = 8'h00;
    localparam logic [7:0] AZ_TIME_RST_S = 8'h14;
    localparam logic [RD_W-1:0] AZ_LVL_RST = 16'h0003;
    localparam logic [7:0] ZSTEP = 8'h01;

    // Timing
    localparam int CLK_HZ = 200_000_000;
    localparam int ZERO_SHORT_MS = 1000;
    localparam int MASTER_PULSE_MS = 250;
    localparam int FW_FLASH_MS = 1000;
    localparam int PWR_BLINK_MS = 1000;
    localparam int OK_BLINK_MS = 500;
    localparam int SEC_CYC = CLK_HZ;
    localparam int MS_CYC = CLK_HZ / 1000;

    typedef enum logic [2:0] {
        CH_DIS = 3'b001,
        CH_ENA = 3'b010,
        CH_ALM = 3'b100
    } fmac_chmode_t;

    typedef enum logic [3:0] {
        AZ_IDLE = 4'b0001,
        AZ_RUN = 4'b0010,
        AZ_DONE = 4'b0100,
        AZ_ERR = 4'b1000
    } fmac_az_t;

    typedef struct packed {
        logic ok;
        logic warn;
        logic alarm;
    } fmac_relay_t;

endpackage

// ---- fmac_top.sv ----
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module fmac_top #(
    parameter int NUM_CH = fmac_pkg::NUM_CH,
    parameter int SEC_CYC = fmac_pkg::SEC_CYC,
    parameter int MS_CYC = fmac_pkg::MS_CYC
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    input wire logic POWER_BUTTON,
    input wire logic GROUP_BUTTON,
    input wire logic SETUP_BUTTON,
    input wire logic EXIT_BUTTON,
    input wire logic TEST_BUTTON,
    input wire logic UP_BUTTON,
    input wire logic DOWN_BUTTON,
    input wire logic PANEL_LOCK_BUTTON,
    input wire logic [NUM_CH-1:0] MODE_BUTTON,
    input wire logic [NUM_CH-1:0] ZERO_BUTTON,
    input wire logic ALARM_RESET_IN,
    input wire logic PSU_FAIL,
    input wire logic [NUM_CH-1:0] PROBE_PRESENT,
    input wire logic [NUM_CH*16-1:0] READING,
    output logic [NUM_CH-1:0] OK_RELAY,
    output logic [NUM_CH-1:0] WARN_RELAY,
    output logic [NUM_CH-1:0] ALARM_RELAY,
    output logic [NUM_CH-1:0] OK_LED,
    output logic [NUM_CH-1:0] WARN_LED,
    output logic [NUM_CH-1:0] ALARM_LED,
    output logic SYS_RELAY,
    output logic PROG_LED,
    output logic LOCK_LED,
    output logic POWER_LED,
    output logic POWER_ON,
    output logic TEST_SHIFT,
    output logic [NUM_CH-1:0] ZERO_ACTIVE,
    output logic [NUM_CH*2-1:0] ZERO_RESULT,
    output logic [NUM_CH*8-1:0] ZERO_COUNTDOWN
);

    // Status word holds up to four channels; the offset read word needs two channels
    if (NUM_CH < 2 || NUM_CH > 4 || SEC_CYC < 2000 || MS_CYC < 2) begin : gparam_chk
        $error("fmac_top: unsupported parameter values");
    end

    localparam int RD_W = fmac_pkg::RD_W;

    ////////////////////////////////////////////////////////////////////////
    // Timebase: ms and second enables, slow toggles

    logic [31:0] ms_cnt_reg;
    logic [31:0] sec_cnt_reg;
    logic ms_tick;
    logic sec_tick;
    logic [15:0] ms_run_reg;

    assign ms_tick = (ms_cnt_reg == 32'(MS_CYC - 1));
    assign sec_tick = (sec_cnt_reg == 32'(SEC_CYC - 1));

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            ms_cnt_reg <= 32'h0;
            sec_cnt_reg <= 32'h0;
            ms_run_reg <= 16'h0;
        end else begin
            ms_cnt_reg <= ms_tick ? 32'h0 : ms_cnt_reg + 32'h1;
            sec_cnt_reg <= sec_tick ? 32'h0 : sec_cnt_reg + 32'h1;
            if (ms_tick)
                ms_run_reg <= ms_run_reg + 16'h1;
        end
    end

    // Blink phases derived from one ms counter, so all LEDs stay in step
    logic master_ph;
    logic fw_ph;
    logic pwr_ph;
    logic ok_ph;
    assign master_ph = (ms_run_reg % 16'(2 * fmac_pkg::MASTER_PULSE_MS)) < 16'(fmac_pkg::MASTER_PULSE_MS / 4);
    assign fw_ph = (ms_run_reg % 16'(2 * fmac_pkg::FW_FLASH_MS)) < 16'(fmac_pkg::FW_FLASH_MS);
    assign pwr_ph = (ms_run_reg % 16'(2 * fmac_pkg::PWR_BLINK_MS)) < 16'(fmac_pkg::PWR_BLINK_MS);
    assign ok_ph = (ms_run_reg % 16'(2 * fmac_pkg::OK_BLINK_MS)) < 16'(fmac_pkg::OK_BLINK_MS);

    ////////////////////////////////////////////////////////////////////////
    // Button edges; inputs are synchronous, edges suffice except where TEST_BUTTON and ZERO_BUTTON are used as levels

    logic [7:0] btn_prev_reg;
    logic [7:0] btn_now;
    logic [7:0] btn_rise;
    logic [NUM_CH-1:0] mode_prev_reg;
    logic [NUM_CH-1:0] zero_prev_reg;

    assign btn_now = {PANEL_LOCK_BUTTON, DOWN_BUTTON, UP_BUTTON, TEST_BUTTON,
                      EXIT_BUTTON, SETUP_BUTTON, GROUP_BUTTON, POWER_BUTTON};
    assign btn_rise = btn_now & ~btn_prev_reg;

    logic alarm_reset_prev_reg;
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            btn_prev_reg <= 8'h0;
            mode_prev_reg <= '0;
            zero_prev_reg <= '0;
            alarm_reset_prev_reg <= 1'b0;
        end else begin
            btn_prev_reg <= btn_now;
            mode_prev_reg <= MODE_BUTTON;
            zero_prev_reg <= ZERO_BUTTON;
            alarm_reset_prev_reg <= ALARM_RESET_IN;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0] ctrl_reg;
    logic [RD_W-1:0] warn_lvl_reg;
    logic [RD_W-1:0] alarm_lvl_reg;
    logic [7:0] delay_s_reg;
    logic [7:0] az_time_reg;
    logic [RD_W-1:0] az_lvl_reg;
    logic lock_reg;
    logic prog_reg;
    logic fw_pending_reg;
    logic power_reg;
    logic cmd_grp;
    logic cmd_reset;
    logic locked_out;

    assign cmd_grp = WR && ADDR == fmac_pkg::REG_CMD && WDATA[fmac_pkg::CMD_GRP_BIT];
    assign cmd_reset = WR && ADDR == fmac_pkg::REG_CMD && WDATA[fmac_pkg::CMD_RESET_BIT];
    assign locked_out = lock_reg;

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            ctrl_reg <= fmac_pkg::CTRL_RST;
            warn_lvl_reg <= fmac_pkg::WARN_RST;
            alarm_lvl_reg <= fmac_pkg::ALARM_RST;
            delay_s_reg <= fmac_pkg::DELAY_RST_S;
            az_time_reg <= fmac_pkg::AZ_TIME_RST_S;
            az_lvl_reg <= fmac_pkg::AZ_LVL_RST;
        end else if (WR) begin
            case (ADDR)
                fmac_pkg::REG_CTRL: ctrl_reg <= WDATA[7:0];
                fmac_pkg::REG_WARN_LVL: warn_lvl_reg <= WDATA;
                fmac_pkg::REG_ALARM_LVL: alarm_lvl_reg <= WDATA;
                fmac_pkg::REG_DELAY: delay_s_reg <= WDATA[7:0];
                fmac_pkg::REG_AZ_TIME: az_time_reg <= WDATA[7:0];
                fmac_pkg::REG_AZ_LVL: az_lvl_reg <= WDATA;
                default: ;
            endcase
        end
    end

    // Panel lock, program mode, power, firmware-update state
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            lock_reg <= 1'b0;
            prog_reg <= 1'b0;
            fw_pending_reg <= 1'b0;
            power_reg <= 1'b1;
        end else begin
            if (WR && ADDR == fmac_pkg::REG_CMD && WDATA[fmac_pkg::CMD_LOCK_SET_BIT])
                lock_reg <= 1'b1;
            else if (WR && ADDR == fmac_pkg::REG_CMD && WDATA[fmac_pkg::CMD_LOCK_CLR_BIT])
                lock_reg <= 1'b0;
            else if (btn_rise[7] && prog_reg)
                lock_reg <= ~lock_reg;
            if (btn_rise[2])
                prog_reg <= 1'b1;
            else if (btn_rise[3])
                prog_reg <= 1'b0;
            // Completion wins over a simultaneous receive start
            if (ctrl_reg[fmac_pkg::CTRL_FWDONE_BIT])
                fw_pending_reg <= 1'b0;
            else if (ctrl_reg[fmac_pkg::CTRL_FWRX_BIT])
                fw_pending_reg <= 1'b1;
            if (btn_rise[0])
                power_reg <= ~power_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-channel logic

    fmac_pkg::fmac_chmode_t mode_reg [NUM_CH];
    fmac_pkg::fmac_relay_t relay_open [NUM_CH];
    logic [NUM_CH-1:0] warn_act;
    logic [NUM_CH-1:0] alarm_act;
    logic [NUM_CH-1:0] ok_open;
    logic [NUM_CH-1:0] ok_led_n;
    logic [NUM_CH*8-1:0] zcount_n;
    logic [7:0] az_show [NUM_CH];
    logic [NUM_CH*8-1:0] zofs_bus;
    logic latching;
    logic ext_reset;

    assign latching = ctrl_reg[fmac_pkg::CTRL_LATCH_BIT];
    assign ext_reset = ALARM_RESET_IN & ~alarm_reset_prev_reg;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g = g + 1) begin : gch
            logic [RD_W-1:0] rd;
            logic [RD_W-1:0] mag;
            logic at_warn;
            logic at_alarm;
            logic [31:0] wdly_reg;
            logic [31:0] adly_reg;
            logic [31:0] dly_lim;
            logic warn_reg;
            logic alarm_reg;
            logic mode_press;
            logic enabled;
            logic [7:0] zofs_reg;
            fmac_pkg::fmac_az_t az_reg;
            logic [7:0] az_cnt_reg;
            logic [31:0] hold_reg;
            logic az_start;

            assign rd = READING[g*RD_W +: RD_W];
            assign mag = rd[RD_W-1] ? RD_W'(-rd) : rd;
            assign at_warn = mag >= warn_lvl_reg;
            assign at_alarm = mag >= alarm_lvl_reg;
            assign dly_lim = 32'(delay_s_reg) * 32'(SEC_CYC);
            assign mode_press = MODE_BUTTON[g] & ~mode_prev_reg[g] & ~locked_out;
            assign enabled = mode_reg[g] != fmac_pkg::CH_DIS;

            always_ff @(posedge CORE_CLK or posedge RST) begin
                if (RST)
                    mode_reg[g] <= fmac_pkg::CH_ENA;
                else if ((btn_rise[1] && !locked_out) || cmd_grp)
                    mode_reg[g] <= fmac_pkg::CH_DIS;
                else if (mode_press) begin
                    case (mode_reg[g])
                        fmac_pkg::CH_DIS: mode_reg[g] <= fmac_pkg::CH_ENA;
                        fmac_pkg::CH_ENA: mode_reg[g] <= fmac_pkg::CH_ALM;
                        default: mode_reg[g] <= fmac_pkg::CH_DIS;
                    endcase
                end
            end

            // Delay counters restart whenever the level is lost before expiry
            always_ff @(posedge CORE_CLK or posedge RST) begin
                if (RST) begin
                    wdly_reg <= 32'h0;
                    adly_reg <= 32'h0;
                end else begin
                    wdly_reg <= !at_warn ? 32'h0 : (wdly_reg < dly_lim ? wdly_reg + 32'h1 : wdly_reg);
                    adly_reg <= !at_alarm ? 32'h0 : (adly_reg < dly_lim ? adly_reg + 32'h1 : adly_reg);
                end
            end

            always_ff @(posedge CORE_CLK or posedge RST) begin
                if (RST) begin
                    warn_reg <= 1'b0;
                    alarm_reg <= 1'b0;
                end else if (mode_reg[g] != fmac_pkg::CH_ALM) begin
                    warn_reg <= 1'b0;
                    alarm_reg <= 1'b0;
                end else begin
                    if (at_warn && wdly_reg >= dly_lim)
                        warn_reg <= 1'b1;
                    else if (!at_warn)
                        warn_reg <= 1'b0;
                    if (at_alarm && adly_reg >= dly_lim)
                        alarm_reg <= 1'b1;
                    else if (!at_warn && (!latching || cmd_reset || ext_reset))
                        alarm_reg <= 1'b0;
                end
            end

            // Zero offset, auto-zero sequencer
            assign az_start = ~ZERO_BUTTON[g] & zero_prev_reg[g] &
                              (hold_reg < 32'(SEC_CYC)) & ~locked_out;
            always_ff @(posedge CORE_CLK or posedge RST) begin
                if (RST) begin
                    hold_reg <= 32'h0;
                    zofs_reg <= 8'h0;
                    az_reg <= fmac_pkg::AZ_IDLE;
                    az_cnt_reg <= 8'h0;
                end else begin
                    // Saturate so a very long hold never wraps into a short press
                    hold_reg <= ZERO_BUTTON[g] ? (hold_reg < 32'(SEC_CYC) ? hold_reg + 32'h1 : hold_reg) : 32'h0;
                    if (ZERO_BUTTON[g] && !locked_out && btn_rise[5])
                        zofs_reg <= zofs_reg + fmac_pkg::ZSTEP;
                    else if (ZERO_BUTTON[g] && !locked_out && btn_rise[6])
                        zofs_reg <= zofs_reg - fmac_pkg::ZSTEP;
                    case (az_reg)
                        fmac_pkg::AZ_RUN: begin
                            if (mag <= az_lvl_reg)
                                az_reg <= fmac_pkg::AZ_DONE;
                            else if (az_cnt_reg == 8'h0)
                                az_reg <= fmac_pkg::AZ_ERR;
                            else if (sec_tick)
                                az_cnt_reg <= az_cnt_reg - 8'h1;
                        end
                        default: if (az_start) begin
                            az_reg <= fmac_pkg::AZ_RUN;
                            az_cnt_reg <= az_time_reg;
                        end
                    endcase
                end
            end

            assign ok_open[g] = !enabled || !PROBE_PRESENT[g];
            assign relay_open[g].ok = ok_open[g];
            assign relay_open[g].warn = warn_reg;
            assign relay_open[g].alarm = alarm_reg || (enabled && !PROBE_PRESENT[g]);
            assign warn_act[g] = relay_open[g].warn;
            assign alarm_act[g] = relay_open[g].alarm;
            assign ok_led_n[g] = !ok_open[g] && (mode_reg[g] == fmac_pkg::CH_ALM ? ok_ph : 1'b1);
            assign az_show[g] = az_reg == fmac_pkg::AZ_RUN ? az_cnt_reg : 8'h0;
            assign zofs_bus[g*8 +: 8] = zofs_reg;

            always_ff @(posedge CORE_CLK or posedge RST) begin
                if (RST) begin
                    ZERO_ACTIVE[g] <= 1'b0;
                    ZERO_RESULT[g*2 +: 2] <= 2'h0;
                end else begin
                    ZERO_ACTIVE[g] <= az_reg == fmac_pkg::AZ_RUN;
                    ZERO_RESULT[g*2 +: 2] <= {az_reg == fmac_pkg::AZ_ERR, az_reg == fmac_pkg::AZ_DONE};
                end
            end
        end
    endgenerate

    // Neighbour on the right shows a countdown; the last channel looks left, so one display may serve two
    always_comb begin
        int tgt;
        tgt = 0;
        zcount_n = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            tgt = (i == NUM_CH - 1) ? i - 1 : i + 1;
            zcount_n[tgt*8 +: 8] = zcount_n[tgt*8 +: 8] | az_show[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output flops; relays drive high when energized (closed)

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            OK_RELAY <= '0;
            WARN_RELAY <= '0;
            ALARM_RELAY <= '0;
            OK_LED <= '0;
            WARN_LED <= '0;
            ALARM_LED <= '0;
            SYS_RELAY <= 1'b0;
            PROG_LED <= 1'b0;
            LOCK_LED <= 1'b0;
            POWER_LED <= 1'b0;
            POWER_ON <= 1'b0;
            TEST_SHIFT <= 1'b0;
            ZERO_COUNTDOWN <= '0;
        end else begin
            OK_RELAY <= ~ok_open;
            WARN_RELAY <= ~warn_act;
            ALARM_RELAY <= ~alarm_act;
            OK_LED <= ok_led_n;
            WARN_LED <= warn_act;
            ALARM_LED <= alarm_act;
            SYS_RELAY <= ~(|alarm_act || PSU_FAIL);
            if (prog_reg)
                PROG_LED <= 1'b1;
            else if (fw_pending_reg || ctrl_reg[fmac_pkg::CTRL_FWRX_BIT])
                PROG_LED <= fw_ph;
            else
                PROG_LED <= ctrl_reg[fmac_pkg::CTRL_MASTER_BIT] && master_ph;
            LOCK_LED <= lock_reg;
            POWER_LED <= PSU_FAIL ? pwr_ph : 1'b1;
            POWER_ON <= power_reg;
            TEST_SHIFT <= TEST_BUTTON && !locked_out;
            ZERO_COUNTDOWN <= zcount_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port: data one cycle after the strobe, zero otherwise

    logic [15:0] chmode_bits;
    always_comb begin
        chmode_bits = 16'h0;
        for (int i = 0; i < NUM_CH; i++)
            chmode_bits[i*3 +: 3] = mode_reg[i];
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST)
            RDATA <= 16'h0;
        else if (RD) begin
            case (ADDR)
                fmac_pkg::REG_CTRL: RDATA <= {8'h0, ctrl_reg};
                fmac_pkg::REG_WARN_LVL: RDATA <= warn_lvl_reg;
                fmac_pkg::REG_ALARM_LVL: RDATA <= alarm_lvl_reg;
                fmac_pkg::REG_DELAY: RDATA <= {8'h0, delay_s_reg};
                fmac_pkg::REG_AZ_TIME: RDATA <= {8'h0, az_time_reg};
                fmac_pkg::REG_AZ_LVL: RDATA <= az_lvl_reg;
                fmac_pkg::REG_STATUS: RDATA <= {2'h0, fw_pending_reg, prog_reg, lock_reg,
                                                 PSU_FAIL, 2'h0, 4'(alarm_act), 4'(warn_act)};
                fmac_pkg::REG_CHMODE: RDATA <= chmode_bits;
                fmac_pkg::REG_ZOFS0: RDATA <= zofs_bus[15:0];
                default: RDATA <= 16'h0;
            endcase
        end else
            RDATA <= 16'h0;
    end

endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    logic CORE_CLK = 1'b0;
    logic RST = 1'b1;
    logic [3:0] ADDR = 4'h0;
    logic [15:0] WDATA = 16'h0;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic TEST_BUTTON = 1'b0;
    logic PSU_FAIL = 1'b0;
    logic [13:0] btn = 14'h0;
    logic [63:0] level = 64'h0;
    logic [3:0] attach = 4'hf;
    logic pulse_req = 1'b0;
    logic [15:0] RDATA;
    logic POWER_BUTTON = 1'b0;
    logic GROUP_BUTTON, SETUP_BUTTON, EXIT_BUTTON, UP_BUTTON, DOWN_BUTTON, PANEL_LOCK_BUTTON;
    logic ALARM_RESET_IN, SYS_RELAY, PROG_LED, LOCK_LED, POWER_LED, POWER_ON, TEST_SHIFT;
    logic [3:0] MODE_BUTTON, ZERO_BUTTON, PROBE_PRESENT, OK_RELAY, WARN_RELAY, ALARM_RELAY;
    logic [3:0] OK_LED, WARN_LED, ALARM_LED, ZERO_ACTIVE;
    logic [63:0] READING;
    logic [7:0] ZERO_RESULT;
    logic [31:0] ZERO_COUNTDOWN;
    logic [15:0] dflt [6] = '{16'h0001, 16'h01f4, 16'h2328, 16'h0000, 16'h0014, 16'h0003};
    logic [15:0] mseq [3] = '{16'h0494, 16'h0491, 16'h0492};
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int lows = 0;
    wire [15:0] ch0 = {11'h0, SYS_RELAY, WARN_RELAY[0], WARN_LED[0], ALARM_RELAY[0], ALARM_LED[0]};
    assign {PANEL_LOCK_BUTTON, DOWN_BUTTON, UP_BUTTON, EXIT_BUTTON, SETUP_BUTTON, GROUP_BUTTON, ZERO_BUTTON,
        MODE_BUTTON} = btn;
    fmac_top #(.SEC_CYC(2000), .MS_CYC(2)) fmac_top_inst (.*);
    fmac_field fmac_field_inst (.clk(CORE_CLK), .level(level), .attach(attach), .pulse_req(pulse_req),
        .reading(READING), .present(PROBE_PRESENT), .contact(ALARM_RESET_IN));
    initial forever #2.5 CORE_CLK = ~CORE_CLK;
    ////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge CORE_CLK);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        wt(1);
        WR <= 1'b0;
        wt(1);
    endtask
    // Read data live only in the cycle after the strobe, so sample exactly there
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        ADDR <= a;
        RD <= 1'b1;
        wt(1);
        RD <= 1'b0;
        @(negedge CORE_CLK);
        chk(RDATA, e);
        wt(1);
    endtask
    task automatic tap(input logic [13:0] m);
        btn <= m;
        wt(1);
        btn <= 14'h0;
        wt(4);
    endtask
    always @(posedge CORE_CLK) begin
        cyc++;
        if (cyc > 40000) begin
            errors++;
            wrap_up();
        end
    end
    ////////////////////////////////////////
    initial begin
        wt(12);
        RST <= 1'b0;
        wt(2);
        foreach (dflt[i]) rd(4'(i), dflt[i]);
        rd(fmac_pkg::REG_CHMODE, 16'h0492);
        rd(4'hf, 16'h0000);
        chk({OK_RELAY, WARN_RELAY, ALARM_RELAY, OK_LED}, 16'hffff);
        foreach (mseq[i]) begin
            tap(14'h0001);
            rd(fmac_pkg::REG_CHMODE, mseq[i]);
        end
        wr(fmac_pkg::REG_CTRL, 16'h0000);
        tap(14'h0001);
        level[15:0] <= 16'h0200;
        wt(6);
        chk(ch0, 16'h0016);
        level[15:0] <= 16'h3000;
        wt(6);
        chk(ch0, 16'h0005);
        level[15:0] <= 16'h0000;
        wt(6);
        chk(ch0, 16'h001a);
        wr(fmac_pkg::REG_CTRL, 16'h0001);
        wr(fmac_pkg::REG_DELAY, 16'h0001);
        level[15:0] <= 16'h3000;
        wt(1000);
        level[15:0] <= 16'h0000;
        wt(5);
        level[15:0] <= 16'h3000;
        wt(1500);
        chk(ch0, 16'h001a);
        wt(700);
        chk(ch0, 16'h0005);
        level[15:0] <= 16'h0000;
        wt(6);
        chk(ch0, 16'h0009);
        pulse_req <= 1'b1;
        wt(1);
        pulse_req <= 1'b0;
        wt(14);
        chk(ch0, 16'h001a);
        level[15:0] <= 16'h3000;
        wt(2100);
        level[15:0] <= 16'h0000;
        wt(4);
        wr(fmac_pkg::REG_CMD, 16'h0002);
        wt(4);
        chk(ch0, 16'h001a);
        wr(fmac_pkg::REG_CMD, 16'h0004);
        tap(14'h0100);
        chk({11'h0, LOCK_LED, OK_RELAY}, 16'h001f);
        for (int p = 0; p < 2; p++) begin
            POWER_BUTTON <= 1'b1;
            wt(1);
            POWER_BUTTON <= 1'b0;
            wt(3);
            chk({15'h0, POWER_ON}, 16'(p));
        end
        rd(fmac_pkg::REG_CHMODE, 16'h0494);
        wr(fmac_pkg::REG_CMD, 16'h0008);
        tap(14'h0100);
        chk({11'h0, LOCK_LED, OK_RELAY}, 16'h0000);
        tap(14'h000f);
        wr(fmac_pkg::REG_CMD, 16'h0001);
        wt(3);
        rd(fmac_pkg::REG_CHMODE, 16'h0249);
        tap(14'h000f);
        attach <= 4'hb;
        wt(5);
        chk({OK_RELAY, ALARM_RELAY, ALARM_LED, 3'h0, SYS_RELAY}, 16'hbb40);
        attach <= 4'hf;
        PSU_FAIL <= 1'b1;
        wt(4);
        chk({15'h0, SYS_RELAY}, 16'h0000);
        repeat (6000) begin
            wt(1);
            lows += int'(POWER_LED == 1'b0);
        end
        chk({15'h0, lows > 0 && lows < 6000}, 16'h0001);
        PSU_FAIL <= 1'b0;
        TEST_BUTTON <= 1'b1;
        wt(5);
        chk({14'h0, POWER_LED, TEST_SHIFT}, 16'h0003);
        TEST_BUTTON <= 1'b0;
        tap(14'h0200);
        chk({14'h0, PROG_LED, TEST_SHIFT}, 16'h0002);
        rd(fmac_pkg::REG_STATUS, 16'h1000);
        tap(14'h0400);
        chk({15'h0, PROG_LED}, 16'h0000);
        wr(fmac_pkg::REG_CTRL, 16'h0003);
        lows = 0;
        repeat (1000) begin
            wt(1);
            lows += int'(PROG_LED);
        end
        chk({15'h0, lows > 0 && lows < 1000}, 16'h0001);
        wr(fmac_pkg::REG_AZ_TIME, 16'h0002);
        tap(14'h0020);
        wt(50);
        chk({4'h0, ZERO_ACTIVE, ZERO_RESULT}, 16'h0004);
        level[31:16] <= 16'h0100;
        tap(14'h0020);
        chk({12'h0, ZERO_ACTIVE}, 16'h0002);
        chk({ZERO_COUNTDOWN[31:24], 7'h0, ZERO_COUNTDOWN[23:16] != 8'h00}, 16'h0001);
        wt(4100);
        chk({4'h0, ZERO_ACTIVE, ZERO_RESULT}, 16'h0008);
        tap(14'h1010);
        rd(fmac_pkg::REG_ZOFS0, 16'h00ff);
        wrap_up();
    end
endmodule
